// file: i2c_status_clear_pec_tb.sv
// i2c_status_clear_pec_tb: self-checking bench for the status/clear/checksum block
`timescale 1ns/10ps
module i2c_status_clear_pec_tb;
  logic        clk, rst, lclk, want_alert, rd_q, reg_wr, reg_rd, ev_start, ev_stop;
  logic        ev_addr_match, ev_addr_read, ev_addr_ten_bit, ev_nak_after_tx, ev_bus_error;
  logic        ev_arb_lost, ev_overrun, ev_bus_timeout, ev_clk_low_timeout, byte_valid;
  logic        byte_is_checksum, alert_pin_n, nak_request, start_request_clear;
  logic        peripheral_enable, checksum_enable;
  logic [7:0]  reg_addr, ev_addr_byte, byte_data, crc;
  logic [31:0] reg_wdata, reg_rdata, rdata2, st;
  logic [3:0]  ctl;
  logic [31:0] exp_q[$];
  logic [7:0]  what_q[$];
  int          mismatches, num_checks, cyc;
  int          evs[5] = '{4, 8, 9, 10, 14};
  int          clr[9] = '{3, 4, 5, 8, 9, 10, 11, 12, 13};
  // block, a copy without bus-management support, far-side device
  i2csc_top dut_u (.*);
  i2csc_top #(.SMBUS_SUPPORTED(1'b0)) dut_nosmb (.*, .reg_rdata(rdata2), .nak_request(),
    .start_request_clear(), .peripheral_enable(), .checksum_enable());
  i2csc_alert_dev dev_u (.lclk(lclk), .want_alert(want_alert), .alert_pin_n(alert_pin_n));
  // clocks, link clock off phase
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    lclk = 1'b0;
    #137;
    forever #200 lclk = ~lclk;
  end
  // ********
  // helpers
  // ********
  function automatic logic [7:0] crc8(logic [7:0] c, logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) r = {r[6:0], 1'b0} ^ (r[7] ? i2csc_pkg::CKS_POLY : 8'h00);
    return r;
  endfunction : crc8
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [31:0] e);
    exp_q.push_back(e);
    what_q.push_back(a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask : rd
  task automatic rd_all();
    rd(i2csc_pkg::OFS_STATUS, st);
    rd(i2csc_pkg::OFS_CHECKSUM, ctl[1] ? {24'h0, crc} : 32'h0);
  endtask : rd_all
  task automatic setctl(logic [3:0] c);
    wr(i2csc_pkg::OFS_CTRL, {28'h0, c});
    ctl = c;
    if (!c[0]) begin
      st[15:0] = 16'h0000;
      crc = 8'h00;
    end
    rd(i2csc_pkg::OFS_CTRL, {28'h0, c});
    chk("enables", {30'h0, c[1:0]}, {30'h0, checksum_enable, peripheral_enable});
  endtask : setctl
  // one-cycle event pulse; 14 stands for the bus timeout
  task automatic pulse(int k);
    @(posedge clk);
    case (k)
      4: ev_nak_after_tx <= 1'b1;
      5: ev_stop <= 1'b1;
      8: ev_bus_error <= 1'b1;
      9: ev_arb_lost <= 1'b1;
      10: ev_overrun <= 1'b1;
      12: ev_clk_low_timeout <= 1'b1;
      14: ev_bus_timeout <= 1'b1;
      default: ev_start <= 1'b1;
    endcase
    @(posedge clk);
    {ev_nak_after_tx, ev_stop, ev_bus_error, ev_arb_lost} <= 4'h0;
    {ev_overrun, ev_clk_low_timeout, ev_bus_timeout, ev_start} <= 4'h0;
    if (ctl[0]) begin
      st[k == 14 ? 12 : k] = 1'b1;
      if (k == 5) begin
        st[15] = 1'b0;
        crc = 8'h00;
      end
    end
  endtask : pulse
  task automatic addr_ev(logic ten);
    logic [7:0] b;
    logic       r;
    b = 8'($urandom);
    r = 1'($urandom);
    if (ten) b[7:3] = 5'b11110;
    @(posedge clk);
    ev_addr_byte <= b;
    ev_addr_read <= r;
    ev_addr_ten_bit <= ten;
    ev_addr_match <= 1'b1;
    @(posedge clk);
    ev_addr_match <= 1'b0;
    st[3] = 1'b1;
    st[16] = r;
    st[23:17] = ten ? {2'b00, b[5:1]} : b[7:1];
  endtask : addr_ev
  task automatic send(logic [7:0] d, logic ck);
    @(posedge clk);
    byte_valid <= 1'b1;
    byte_data <= d;
    byte_is_checksum <= ck;
    @(posedge clk);
    byte_valid <= 1'b0;
    @(negedge clk);
    if (ck) begin
      chk("nak_request", {31'h0, d != crc}, {31'h0, nak_request});
      st[11] = st[11] | (d != crc);
      crc = 8'h00;
    end else crc = crc8(crc, d);
  endtask : send
  task automatic alert();
    @(posedge clk);
    want_alert <= 1'b1;
    repeat (30) @(posedge clk);
    want_alert <= 1'b0;
    repeat (30) @(posedge clk);
    if (ctl == 4'hf) st[13] = 1'b1;
    rd_all();
  endtask : alert
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude
  // result watcher: oldest note against the returned word, both builds
  always @(posedge clk) begin
    if (rd_q) begin
      chk($sformatf("reg_%h", what_q[0]), exp_q[0], reg_rdata);
      chk($sformatf("nosmb_%h", what_q.pop_front()), exp_q.pop_front() & ~32'h3800, rdata2);
    end
    rd_q <= reg_rd;
  end
  // hang guard, far beyond the test length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      conclude();
    end
  end
  // ********
  // tests
  // ********
  initial begin
    {want_alert, rd_q, reg_wr, reg_rd, ev_start, ev_stop, ev_addr_match, ev_addr_read} = 8'h00;
    {ev_addr_ten_bit, ev_nak_after_tx, ev_bus_error, ev_arb_lost, ev_overrun} = 5'h00;
    {ev_bus_timeout, ev_clk_low_timeout, byte_valid, byte_is_checksum} = 4'h0;
    {reg_addr, ev_addr_byte, byte_data, crc, ctl} = 36'h0;
    {reg_wdata, st} = 64'h0;
    void'($urandom(96));
    rst = 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(i2csc_pkg::OFS_CTRL, 32'h0);
    rd(i2csc_pkg::OFS_CLEAR, 32'h0);
    wr(i2csc_pkg::OFS_STATUS, 32'hffff_ffff);
    wr(i2csc_pkg::OFS_CHECKSUM, 32'hffff_ffff);
    wr(8'h04, 32'hffff_ffff);
    rd(8'h04, 32'h0);
    pulse(8);
    rd_all();
    $display("test 1 done");
    setctl(4'hf);
    pulse(15);
    rd_all();
    addr_ev(1'b0);
    rd_all();
    addr_ev(1'b1);
    rd_all();
    foreach (evs[i]) begin
      pulse(evs[i]);
      rd_all();
    end
    $display("test 2 done");
    repeat (5) send(8'($urandom), 1'b0);
    rd_all();
    send(crc, 1'b1);
    send(8'($urandom), 1'b0);
    send(~crc, 1'b1);
    rd_all();
    $display("test 3 done");
    setctl(4'h3);
    alert();
    setctl(4'hf);
    alert();
    pulse(5);
    rd_all();
    $display("test 4 done");
    wr(i2csc_pkg::OFS_CLEAR, 32'h0);
    rd_all();
    foreach (clr[i]) begin
      wr(i2csc_pkg::OFS_CLEAR, 32'h1 << clr[i]);
      st[clr[i]] = 1'b0;
      rd_all();
    end
    $display("test 5 done");
    // clock-low timeout on a cleared flag, apart from the bus timeout
    pulse(12);
    rd_all();
    repeat (3) send(8'($urandom), 1'b0);
    pulse(15);
    pulse(10);
    setctl(4'h0);
    rd_all();
    pulse(15);
    setctl(4'h3);
    rd_all();
    $display("test 6 done");
    repeat (3) @(posedge clk);
    conclude();
  end
endmodule : i2c_status_clear_pec_tb
bind i2csc_top i2csc_checker chk_u (.*);

// file: i2csc_alert_dev.sv
// i2csc_alert_dev: far-side device that pulls the shared alert line
`timescale 1ns/10ps
module i2csc_alert_dev (
  // own clock and request
  input wire logic lclk,
  input wire logic want_alert,
  // open-drain alert line
  output logic     alert_pin_n
);
  logic drive_q = 1'b0;
  // device moves the line on its own clock, unrelated to the block's
  always_ff @(posedge lclk) begin
    drive_q <= want_alert;
  end
  // released line returns to its pull-up
  assign alert_pin_n = drive_q ? 1'b0 : 1'b1;
endmodule : i2csc_alert_dev

// file: i2csc_assertions.sv
// i2csc_assertions: port-level checker for the status/clear/checksum block
`timescale 1ns/10ps
module i2csc_checker (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // events and outputs
  input wire logic        ev_start,
  input wire logic        ev_stop,
  input wire logic        ev_addr_match,
  input wire logic        ev_addr_read,
  input wire logic        ev_addr_ten_bit,
  input wire logic [7:0]  ev_addr_byte,
  input wire logic        byte_valid,
  input wire logic        byte_is_checksum,
  input wire logic        nak_request,
  input wire logic        start_request_clear,
  input wire logic        peripheral_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [6:0] code_now;
  // code that a match in this cycle should leave behind
  assign code_now = ev_addr_ten_bit ? {2'b00, ev_addr_byte[5:1]} : ev_addr_byte[7:1];
  // ********
  // sequences
  // ********
  sequence s_off;
    !peripheral_enable;
  endsequence
  sequence s_match;
    peripheral_enable && ev_addr_match;
  endsequence
  sequence s_st_rd;
    reg_rd && reg_addr == i2csc_pkg::OFS_STATUS && peripheral_enable && !ev_addr_match && !ev_stop;
  endsequence
  // quiet cycle between an event and the read that reports it
  sequence s_calm;
    peripheral_enable && !ev_addr_match && !ev_stop;
  endsequence
  // ********
  // properties
  // ********
  property p_clr0;
    reg_rd && reg_addr == i2csc_pkg::OFS_CLEAR |=> reg_rdata == 32'h0000_0000;
  endproperty
  a_clr0: assert property (p_clr0) else $error("clear reg read nonzero");
  property p_rsv;
    reg_rd && reg_addr == i2csc_pkg::OFS_STATUS |=> reg_rdata[31:24] == 8'h00 && !reg_rdata[14];
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved status bits set");
  property p_srq;
    reg_wr && reg_addr == i2csc_pkg::OFS_CLEAR && reg_wdata[3] |=> start_request_clear;
  endproperty
  a_srq: assert property (p_srq) else $error("start request not cleared");
  property p_nak;
    nak_request |-> $past(byte_valid) && $past(byte_is_checksum);
  endproperty
  a_nak: assert property (p_nak) else $error("nak without checksum byte");
  // the bench reads two edges after the event, so one quiet cycle sits between
  property p_busy;
    (peripheral_enable && ev_start && !ev_stop) ##1 s_calm ##1 s_st_rd |=> reg_rdata[15];
  endproperty
  a_busy: assert property (p_busy) else $error("busy not set by start");
  property p_dir;
    s_match ##1 s_calm ##1 s_st_rd |=> reg_rdata[16] == $past(ev_addr_read, 3);
  endproperty
  a_dir: assert property (p_dir) else $error("direction not loaded");
  property p_code;
    s_match ##1 s_calm ##1 s_st_rd |=> reg_rdata[23:17] == $past(code_now, 3);
  endproperty
  a_code: assert property (p_code) else $error("address code not loaded");
  property p_offf;
    s_off ##1 (!peripheral_enable && reg_rd && reg_addr == i2csc_pkg::OFS_STATUS)
      |=> reg_rdata[15:3] == 13'h0000;
  endproperty
  a_offf: assert property (p_offf) else $error("flags kept while disabled");
endmodule : i2csc_checker

// file: i2csc_crc8.sv
// i2csc_crc8: one-byte step of the 8-bit bus checksum, purely combinational
`timescale 1ns/10ps
module i2csc_crc8 (
  // running value and new byte
  input  wire logic [7:0] crc_in,
  input  wire logic [7:0] data_in,
  // value after the byte
  output logic [7:0]      crc_out
);

  // msb-first shift, one bit per loop pass
  always_comb begin
    logic [7:0] c;
    c = crc_in ^ data_in;
    for (int i = 0; i < 8; i++) begin
      if (c[7]) begin
        c = {c[6:0], 1'b0} ^ i2csc_pkg::CKS_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    crc_out = c;
  end

endmodule : i2csc_crc8

// file: i2csc_pkg.sv
// i2csc_pkg: offsets, field positions, reset values and constants for the status/clear/checksum block
package i2csc_pkg;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h18;
  localparam logic [7:0] OFS_CLEAR    = 8'h1c;
  localparam logic [7:0] OFS_CHECKSUM = 8'h20;

  // ****************************************
  // control register fields
  // ****************************************
  localparam int CTRL_PERIPH_EN  = 0;
  localparam int CTRL_CHECKSUM_EN = 1;
  localparam int CTRL_HOST_ADDR_EN = 2;
  localparam int CTRL_ALERT_EN   = 3;
  localparam int CTRL_W          = 4;

  // ****************************************
  // status and clear bit positions
  // ****************************************
  localparam int BIT_ADDR_MATCH = 3;
  localparam int BIT_NAK        = 4;
  localparam int BIT_STOP       = 5;
  localparam int BIT_BUS_ERR    = 8;
  localparam int BIT_ARB_LOST   = 9;
  localparam int BIT_OVERRUN    = 10;
  localparam int BIT_CKS_ERR    = 11;
  localparam int BIT_TIMEOUT    = 12;
  localparam int BIT_ALERT      = 13;
  localparam int BIT_BUSY       = 15;
  localparam int BIT_DIR        = 16;
  localparam int BIT_CODE_LO    = 17;
  localparam int BIT_CODE_HI    = 23;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [CTRL_W-1:0] RST_CTRL     = 4'h0;
  localparam logic [7:0]        RST_CHECKSUM = 8'h00;
  localparam logic [6:0]        RST_CODE     = 7'h00;
  localparam logic [31:0]       RST_RDATA    = 32'h0000_0000;

  // ****************************************
  // checksum polynomial x^8 + x^2 + x + 1
  // ****************************************
  localparam logic [7:0] CKS_POLY = 8'h07;

  // synchroniser depth for pin inputs
  localparam int SYNC_STAGES = 2;

endpackage : i2csc_pkg

// file: i2csc_sync2.sv
// i2csc_sync2: two flip-flop synchroniser for one asynchronous pin
`timescale 1ns/10ps
module i2csc_sync2 #(
  parameter logic RST_VAL = 1'b1
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // pin in, synchronised level out
  input  wire logic pin_async,
  output logic      pin_sync
);

  typedef struct packed {
    logic meta;
    logic stable;
  } i2csc_sync_s;

  i2csc_sync_s s_q;
  i2csc_sync_s s_d;

  // first stage feeds only the second stage
  always_comb begin
    s_d        = s_q;
    s_d.meta   = pin_async;
    s_d.stable = s_q.meta;
  end

  // constant reset keeps the idle-high pin from faking an edge
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '{meta: RST_VAL, stable: RST_VAL};
    end else begin
      s_q <= s_d;
    end
  end

  assign pin_sync = s_q.stable;

endmodule : i2csc_sync2

// file: i2csc_top.sv
// i2csc_top: upper status flags, write-one-to-clear register and checksum value of the bus controller
// ****************************************
// How it works
// - checksum byte unlike the running checksum sets status bit 11
// - a mismatching checksum byte is answered with a not-acknowledge
// - without bus-management support bits 11-13 and their clears read zero
// - bus timeout or external clock-low timeout sets status bit 12
// - alert pin falling edge sets bit 13 when host address and alert enabled
// - start sets busy bit 15; stop or disable clears it
// - each address match loads bit 16: 0 write/slave receives, 1 read
// - each address match loads the received address code into bits 23:17
// - ten-bit headers store the address part after the first two bits
// - clear bit 3 clears address match flag and the start request
// - clear bit 4 clears the not-acknowledge received flag
// - clear bit 5 clears the stop seen flag
// - clear bits 8, 9, 10 clear bus error, arbitration lost, overrun
// - clear bits 11, 12, 13 clear checksum mismatch, timeout, alert
// - with checksum enabled, checksum register bits 7:0 show the running value
// - running checksum returns to zero while the peripheral is disabled
// - overrun flag cleared by its clear bit or while disabled
// - a received address matching a valid own address sets the match flag
// - a not-acknowledge after a transmitted byte sets the nak flag
// ****************************************
`timescale 1ns/10ps
module i2csc_top #(
  parameter logic SMBUS_SUPPORTED = 1'b1
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // bus events from the protocol engine
  input  wire logic        ev_start,
  input  wire logic        ev_stop,
  input  wire logic        ev_addr_match,
  input  wire logic        ev_addr_read,
  input  wire logic        ev_addr_ten_bit,
  input  wire logic [7:0]  ev_addr_byte,
  input  wire logic        ev_nak_after_tx,
  input  wire logic        ev_bus_error,
  input  wire logic        ev_arb_lost,
  input  wire logic        ev_overrun,
  input  wire logic        ev_bus_timeout,
  input  wire logic        ev_clk_low_timeout,
  // bytes seen on the bus
  input  wire logic        byte_valid,
  input  wire logic [7:0]  byte_data,
  input  wire logic        byte_is_checksum,
  // alert pin
  input  wire logic        alert_pin_n,
  // to the protocol engine and control logic
  output logic             nak_request,
  output logic             start_request_clear,
  output logic             peripheral_enable,
  output logic             checksum_enable
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    // software control bits
    logic [i2csc_pkg::CTRL_W-1:0] ctrl;
    // sticky event and error flags
    logic        addr_match_flag;
    logic        nak_received_flag;
    logic        stop_seen_flag;
    logic        bus_error_flag;
    logic        arb_lost_flag;
    logic        overrun_flag;
    logic        checksum_mismatch_flag;
    logic        timeout_error_flag;
    logic        alert_seen_flag;
    // bus state and the last address record
    logic        line_occupied_flag;
    logic        transfer_direction_flag;
    logic [6:0]  matched_address_code;
    // running checksum and alert edge history
    logic [7:0]  checksum;
    logic        alert_prev;
    // registered outputs
    logic [31:0] rdata;
    logic        nak_req;
    logic        start_clr;
  } i2csc_state_s;

  i2csc_state_s s_q;
  i2csc_state_s s_d;

  // nets between the helpers and the next-state logic
  logic       alert_sync;
  logic [7:0] checksum_next;
  logic [31:0] status_word;
  logic        wr_clear;
  logic        en;
  logic        smb_en;
  logic        alert_fall;
  logic        cks_bad;

  // ****************************************
  // helpers
  // ****************************************
  // alert pin passes two flops before the edge detector sees it
  i2csc_sync2 #(
    .RST_VAL  (1'b1)
  ) u_alert_sync (
    .clk      (clk),
    .rst      (rst),
    .pin_async(alert_pin_n),
    .pin_sync (alert_sync)
  );

  // running checksum advanced by one byte
  i2csc_crc8 u_crc (
    .crc_in (s_q.checksum),
    .data_in(byte_data),
    .crc_out(checksum_next)
  );

  // decoded strobes and qualifiers
  // writes need no qualifier: the slave never stalls the master
  assign en         = s_q.ctrl[i2csc_pkg::CTRL_PERIPH_EN];
  assign smb_en     = SMBUS_SUPPORTED & en;
  assign wr_clear   = reg_wr && (reg_addr == i2csc_pkg::OFS_CLEAR);
  // pin idles high, so a low after a high is the falling edge
  assign alert_fall = s_q.alert_prev & ~alert_sync;
  // checksum byte compared against the value built from the bytes before it
  assign cks_bad    = en && byte_valid && byte_is_checksum
                      && (byte_data != s_q.checksum);

  // ****************************************
  // status word as read by software
  // ****************************************
  // lower bits 0-2, 6 and 7 live elsewhere and read zero here
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[i2csc_pkg::BIT_ADDR_MATCH] = s_q.addr_match_flag;
    status_word[i2csc_pkg::BIT_NAK]        = s_q.nak_received_flag;
    status_word[i2csc_pkg::BIT_STOP]       = s_q.stop_seen_flag;
    status_word[i2csc_pkg::BIT_BUS_ERR]    = s_q.bus_error_flag;
    status_word[i2csc_pkg::BIT_ARB_LOST]   = s_q.arb_lost_flag;
    status_word[i2csc_pkg::BIT_OVERRUN]    = s_q.overrun_flag;
    // bus-management flags forced low without support
    status_word[i2csc_pkg::BIT_CKS_ERR]    = SMBUS_SUPPORTED & s_q.checksum_mismatch_flag;
    status_word[i2csc_pkg::BIT_TIMEOUT]    = SMBUS_SUPPORTED & s_q.timeout_error_flag;
    status_word[i2csc_pkg::BIT_ALERT]      = SMBUS_SUPPORTED & s_q.alert_seen_flag;
    // bus state record, never cleared by software
    status_word[i2csc_pkg::BIT_BUSY]       = s_q.line_occupied_flag;
    status_word[i2csc_pkg::BIT_DIR]        = s_q.transfer_direction_flag;
    status_word[i2csc_pkg::BIT_CODE_HI:i2csc_pkg::BIT_CODE_LO] = s_q.matched_address_code;
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.nak_req   = 1'b0;
    s_d.start_clr = 1'b0;
    s_d.alert_prev = alert_sync;

    // control register write; the only write that stores a value
    if (reg_wr && (reg_addr == i2csc_pkg::OFS_CTRL)) begin
      s_d.ctrl = reg_wdata[i2csc_pkg::CTRL_W-1:0];
    end

    // write-one-to-clear; a zero leaves its flag alone
    // the clear register keeps no storage of its own
    if (wr_clear) begin
      if (reg_wdata[i2csc_pkg::BIT_ADDR_MATCH]) begin
        s_d.addr_match_flag = 1'b0;
        s_d.start_clr       = 1'b1;
      end
      if (reg_wdata[i2csc_pkg::BIT_NAK]) begin
        s_d.nak_received_flag = 1'b0;
      end
      if (reg_wdata[i2csc_pkg::BIT_STOP]) begin
        s_d.stop_seen_flag = 1'b0;
      end
      if (reg_wdata[i2csc_pkg::BIT_BUS_ERR]) begin
        s_d.bus_error_flag = 1'b0;
      end
      if (reg_wdata[i2csc_pkg::BIT_ARB_LOST]) begin
        s_d.arb_lost_flag = 1'b0;
      end
      if (reg_wdata[i2csc_pkg::BIT_OVERRUN]) begin
        s_d.overrun_flag = 1'b0;
      end
      // clears above bit 10 are reserved without support
      if (reg_wdata[i2csc_pkg::BIT_CKS_ERR] && SMBUS_SUPPORTED) begin
        s_d.checksum_mismatch_flag = 1'b0;
      end
      if (reg_wdata[i2csc_pkg::BIT_TIMEOUT] && SMBUS_SUPPORTED) begin
        s_d.timeout_error_flag = 1'b0;
      end
      if (reg_wdata[i2csc_pkg::BIT_ALERT] && SMBUS_SUPPORTED) begin
        s_d.alert_seen_flag = 1'b0;
      end
    end

    // hardware sets come after the clears so a same-cycle event survives
    if (en) begin
      if (ev_addr_match) begin
        s_d.addr_match_flag         = 1'b1;
        s_d.transfer_direction_flag = ev_addr_read;
        // ten-bit header: drop the two leading header bits
        if (ev_addr_ten_bit) begin
          s_d.matched_address_code = {2'b00, ev_addr_byte[5:1]};
        end else begin
          s_d.matched_address_code = ev_addr_byte[7:1];
        end
      end
      // plain event flags: set here, cleared by software or disable
      if (ev_nak_after_tx) begin
        s_d.nak_received_flag = 1'b1;
      end
      if (ev_stop) begin
        s_d.stop_seen_flag = 1'b1;
      end
      if (ev_bus_error) begin
        s_d.bus_error_flag = 1'b1;
      end
      if (ev_arb_lost) begin
        s_d.arb_lost_flag = 1'b1;
      end
      if (ev_overrun) begin
        s_d.overrun_flag = 1'b1;
      end
      // start then stop in one cycle leaves the line free
      if (ev_start) begin
        s_d.line_occupied_flag = 1'b1;
      end
      if (ev_stop) begin
        s_d.line_occupied_flag = 1'b0;
      end
    end

    // bus-management events, inert without support
    if (smb_en) begin
      if (cks_bad) begin
        s_d.checksum_mismatch_flag = 1'b1;
        s_d.nak_req                = 1'b1;
      end
      // either timeout source lands on the same flag
      if (ev_bus_timeout || ev_clk_low_timeout) begin
        s_d.timeout_error_flag = 1'b1;
      end
      if (alert_fall && s_q.ctrl[i2csc_pkg::CTRL_HOST_ADDR_EN]
          && s_q.ctrl[i2csc_pkg::CTRL_ALERT_EN]) begin
        s_d.alert_seen_flag = 1'b1;
      end
    end

    // running checksum: every data byte folds in, the checksum byte restarts it
    // the checksum byte itself is compared, never folded in
    if (en && byte_valid) begin
      if (byte_is_checksum) begin
        s_d.checksum = i2csc_pkg::RST_CHECKSUM;
      end else begin
        s_d.checksum = checksum_next;
      end
    end else if (en && ev_stop) begin
      // a frame ended without its checksum must not leak into the next
      s_d.checksum = i2csc_pkg::RST_CHECKSUM;
    end

    // disabling wipes every flag except direction, and the checksum
    // disable wins over every set above; direction and code keep value
    if (!en) begin
      s_d.addr_match_flag        = 1'b0;
      s_d.nak_received_flag      = 1'b0;
      s_d.stop_seen_flag         = 1'b0;
      s_d.bus_error_flag         = 1'b0;
      s_d.arb_lost_flag          = 1'b0;
      s_d.overrun_flag           = 1'b0;
      s_d.checksum_mismatch_flag = 1'b0;
      s_d.timeout_error_flag     = 1'b0;
      s_d.alert_seen_flag        = 1'b0;
      s_d.line_occupied_flag     = 1'b0;
      s_d.checksum               = i2csc_pkg::RST_CHECKSUM;
    end

    // read data stand only in the cycle after the strobe
    s_d.rdata = i2csc_pkg::RST_RDATA;
    if (reg_rd) begin
      case (reg_addr)
        i2csc_pkg::OFS_CTRL: begin
          s_d.rdata = {28'h000_0000, s_q.ctrl};
        end
        i2csc_pkg::OFS_STATUS: begin
          s_d.rdata = status_word;
        end
        i2csc_pkg::OFS_CLEAR: begin
          s_d.rdata = i2csc_pkg::RST_RDATA;
        end
        i2csc_pkg::OFS_CHECKSUM: begin
          // value hidden while checksumming is off
          if (s_q.ctrl[i2csc_pkg::CTRL_CHECKSUM_EN]) begin
            s_d.rdata = {24'h00_0000, s_q.checksum};
          end
        end
        // unmapped addresses fall here and read zero
        default: begin
          s_d.rdata = i2csc_pkg::RST_RDATA;
        end
      endcase
    end
  end

  // ****************************************
  // registers
  // ****************************************
  // one flop bank for all state; reset is synchronous like the rest
  // and loads constants only, so no reset path reads live logic
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '{
        ctrl:                    i2csc_pkg::RST_CTRL,
        matched_address_code:    i2csc_pkg::RST_CODE,
        checksum:                i2csc_pkg::RST_CHECKSUM,
        alert_prev:              1'b1,
        rdata:                   i2csc_pkg::RST_RDATA,
        default:                 1'b0
      };
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // outputs, all straight from flops
  // ****************************************
  // nothing combinational reaches a pin, so no glitch leaves the block
  assign reg_rdata           = s_q.rdata;
  assign nak_request         = s_q.nak_req;
  assign start_request_clear = s_q.start_clr;
  assign peripheral_enable   = s_q.ctrl[i2csc_pkg::CTRL_PERIPH_EN];
  assign checksum_enable     = s_q.ctrl[i2csc_pkg::CTRL_CHECKSUM_EN];

endmodule : i2csc_top
